// ===== verilog/dpo_pkg.sv
`default_nettype none
package dpo_pkg;
  // register byte addresses on apb (word aligned)
  localparam logic [7:0]  ADDR_SHIFT_LOW   = 8'h00;
  localparam logic [7:0]  ADDR_SHIFT_HIGH  = 8'h04;
  localparam logic [7:0]  ADDR_CONTROL     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS      = 8'h0C;
  localparam logic [7:0]  ADDR_APPLIED     = 8'h10;
  // reset values
  localparam logic [7:0]  RST_SHIFT_BYTE   = 8'h00;
  localparam logic [2:0]  RST_CONTROL      = 3'h0;
  // control field positions
  localparam int          CTL_RAMP_OFF_BIT = 0;
  localparam int          CTL_LOCKED_BIT   = 1;
  localparam int          CTL_PBO_BIT      = 2;
  // status field positions
  localparam int          STS_RAMPING_BIT  = 0;
  localparam int          STS_IGNORED_BIT  = 1;
  // step size: one lsb is the 77.76 MHz period over 2**11
  localparam real         STEP_PS          = 6.279;
  localparam int          STEP_FRAC_BITS   = 11;
  localparam logic [15:0] HALF_CYCLE_VALUE = 16'h0400;
  // ramp pace: one lsb per this many core clocks
  localparam int          RAMP_DIV_CYCLES  = 8;
endpackage
`default_nettype wire

// ===== verilog/dpo_ramp.sv
`timescale 1ns/100ps
`default_nettype none
module dpo_ramp
  import dpo_pkg::*;
#(
  parameter int DIV = RAMP_DIV_CYCLES
) (
  input  wire logic               core_clk,  // system clock
  input  wire logic               sys_rst,   // sync reset
  input  wire logic signed [15:0] target,    // programmed offset
  input  wire logic               ramp_en,   // gradual move allowed
  output logic signed [15:0]      applied,   // offset in use
  output logic                    ramping    // not yet at target
);
  logic [$clog2(DIV+1)-1:0] pace;
  wire pace_hit = (pace == '0);

  always_ff @(posedge core_clk) begin
    if (sys_rst || !ramping || pace_hit) begin
      pace <= ($clog2(DIV+1))'(DIV - 1);
    end else begin
      pace <= pace - 1'b1;
    end
  end

  // single lsb steps keep the move monotonic and land exactly on target
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      applied <= '0;
    end else if (!ramp_en) begin
      applied <= target;
    end else if (pace_hit && applied < target) begin
      applied <= applied + 16'sd1;
    end else if (pace_hit && applied > target) begin
      applied <= applied - 16'sd1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ramping <= 1'b0;
    end else begin
      ramping <= ramp_en && (applied != target);
    end
  end
endmodule // dpo_ramp
`default_nettype wire

// ===== verilog/dpo_phase_offset.sv
// Notes on behaviour
// - output shift is offset times about 6.279 ps.
// - one lsb is the 77.76 MHz period divided by 2**11.
// - true step follows actual clock period, reference or free-run.
// - value 1024 shifts half a cycle, inverting the output clock.
// - when locked, a new offset is reached gradually, not by jumping.
// - ramping may be disabled for holdover-only changes; then applied directly.
// - offset is ignored entirely while phase build-out is enabled.
// - high byte is read/write and resets to zero.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module dpo_phase_offset
  import dpo_pkg::*;
#(
  parameter int RAMP_DIV = RAMP_DIV_CYCLES        // core clocks per ramp step
) (
  input  wire logic        core_clk,      // 125 MHz system clock
  input  wire logic        sys_rst,       // sync reset, active high
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb write
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic [31:0]      prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  output logic [15:0]      phase_shift,   // offset handed to output phase logic
  output logic             inverted       // output sits half a cycle shifted
);

  // programmed bytes and control
  logic [7:0]         shift_low;
  logic [7:0]         shift_high;
  logic [2:0]         control;
  logic signed [15:0] applied;
  logic               ramping;

  // bus decode
  logic               setup;
  logic               rd_setup;
  logic               wr_hit;
  logic               wr_low;
  logic               wr_high;
  logic               wr_control;

  // control fields and offset path
  logic               ramp_off;
  logic               dpll_locked;
  logic               pbo_on;
  logic signed [15:0] target;
  logic               ramp_en;

  // next values of the registered outputs
  logic [31:0]        status_word;
  logic [31:0]        next_rdata;
  logic [15:0]        next_shift;
  logic               next_inverted;

  // true for the five mapped word addresses
  function automatic logic addr_known(input logic [7:0] a);
    case (a)
      ADDR_SHIFT_LOW,
      ADDR_SHIFT_HIGH,
      ADDR_CONTROL,
      ADDR_STATUS,
      ADDR_APPLIED: addr_known = 1'b1;
      default:      addr_known = 1'b0;
    endcase
  endfunction

  // strobe for one register address
  function automatic logic write_to(input logic [7:0] a, input logic [7:0] reg_addr, input logic strobe);
    write_to = strobe && (a == reg_addr);
  endfunction

  // zero-extend one register byte to a bus word
  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h00_0000, b};
  endfunction

  // half a cycle of shift flips the output clock
  function automatic logic is_half_cycle(input logic signed [15:0] value);
    is_half_cycle = (value == $signed(HALF_CYCLE_VALUE));
  endfunction

  // a write lands only on the edge that samples pready high
  assign setup      = psel && !penable;
  assign rd_setup   = setup && !pwrite;
  assign wr_hit     = psel && penable && pready && pwrite;
  assign wr_low     = write_to(paddr, ADDR_SHIFT_LOW, wr_hit);
  assign wr_high    = write_to(paddr, ADDR_SHIFT_HIGH, wr_hit);
  assign wr_control = write_to(paddr, ADDR_CONTROL, wr_hit);

  // locked and build-out are software bits; no loop lives in this block
  assign ramp_off    = control[CTL_RAMP_OFF_BIT];
  assign dpll_locked = control[CTL_LOCKED_BIT];
  assign pbo_on      = control[CTL_PBO_BIT];

  // no wait state: ready rises in the first access cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // unmapped words answer with an error and never store
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !addr_known(paddr);
    end else begin
      pslverr <= 1'b0;
    end
  end

  // each byte lands alone, so a two-byte change passes through a mixed value
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shift_high <= RST_SHIFT_BYTE;
    end else if (wr_high) begin
      shift_high <= pwdata[7:0];
    end
  end

  // low byte pairs with the high byte into one signed offset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shift_low <= RST_SHIFT_BYTE;
    end else if (wr_low) begin
      shift_low <= pwdata[7:0];
    end
  end

  // bit 0 ramp off, bit 1 locked, bit 2 build-out
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      control <= RST_CONTROL;
    end else if (wr_control) begin
      control <= pwdata[2:0];
    end
  end

  // status and applied words are read-only; writes to them are dropped
  always_comb begin
    // bits above the two flags read as zero
    status_word                  = '0;
    status_word[STS_RAMPING_BIT] = ramping;
    status_word[STS_IGNORED_BIT] = pbo_on;
  end

  // read data is captured at setup and holds until the next read setup
  always_comb begin
    unique case (paddr)
      ADDR_SHIFT_LOW:  next_rdata = byte_word(shift_low);
      ADDR_SHIFT_HIGH: next_rdata = byte_word(shift_high);
      ADDR_CONTROL:    next_rdata = {29'h0000_0000, control};
      ADDR_STATUS:     next_rdata = status_word;
      ADDR_APPLIED:    next_rdata = {16'h0000, applied};
      // unmapped words read as zero
      default:         next_rdata = '0;
    endcase
  end

  // holding between reads lets a slow master take the word late
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= next_rdata;
    end
  end

  // target moves after every byte write
  assign target  = {shift_high, shift_low};
  // ramp only when locked and not disabled by software
  assign ramp_en = dpll_locked && !ramp_off;

  // single lsb steps at a fixed pace
  dpo_ramp #(.DIV(RAMP_DIV)) u_ramp (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .target   (target),
    .ramp_en  (ramp_en),
    .applied  (applied),
    .ramping  (ramping)
  );

  // lsb units of period/2**11 (about 6.279 ps); real size tracks the clock in use
  always_comb begin
    if (pbo_on) begin
      next_shift    = '0;
      next_inverted = 1'b0;
    end else begin
      next_shift    = applied;
      next_inverted = is_half_cycle(applied);
    end
  end

  // outputs come straight from flip-flops
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      phase_shift <= '0;
    end else begin
      phase_shift <= next_shift;
    end
  end

  // flag follows the shift actually applied, not the target
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      inverted <= 1'b0;
    end else begin
      inverted <= next_inverted;
    end
  end
endmodule // dpo_phase_offset
`default_nettype wire

// ===== testbench/dpo_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module dpo_chk (
  input wire logic        core_clk,     // system clock
  input wire logic        sys_rst,      // sync reset
  input wire logic        psel,         // apb select
  input wire logic        penable,      // apb access phase
  input wire logic        pwrite,       // apb write
  input wire logic [7:0]  paddr,        // apb address
  input wire logic [31:0] pwdata,       // apb write data
  input wire logic [31:0] prdata,       // apb read data
  input wire logic        pready,       // apb ready
  input wire logic        pslverr,      // apb error
  input wire logic        inverted,     // half-cycle flag
  input wire logic [15:0] phase_shift   // applied offset
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy1; pready |=> !pready; endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready longer than one cycle");
  property p_err; pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}); endproperty
  a_err: assert property (p_err) else $error("error flag wrong for address");
  property p_errq; pslverr |-> pready; endproperty
  a_errq: assert property (p_errq) else $error("error without ready");
  property p_rdz; pready && pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
  a_rdz: assert property (p_rdz) else $error("unmapped read not zero");
  property p_hold; !(psel && !penable) |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_inv; inverted |-> phase_shift == 16'h0400; endproperty
  a_inv: assert property (p_inv) else $error("inversion flag without half cycle");
  property p_rst; $past(sys_rst) |-> phase_shift == 16'h0000 && !inverted; endproperty
  a_rst: assert property (p_rst) else $error("offset not zero after reset");
  c_wr: cover property (pready && pwrite && paddr == 8'h04);
  c_inv: cover property (inverted);
  c_err: cover property (pslverr);
endmodule // dpo_chk
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dpo_pkg::*;
  logic        core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, inverted, err;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] phase_shift, v;
  int          n_mismatch = 0, compares = 0, seed = 32'h112d9940;
  dpo_phase_offset i_dpo_phase_offset (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .phase_shift, .inverted);
  initial forever #4 core_clk = ~core_clk;
  task automatic test_done;
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin n_mismatch++; test_done; end
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // write lands on the access edge, applied one edge later, output one more
  task automatic settle; repeat (3) @(posedge core_clk); endtask
  function automatic logic [15:0] exp_offset(input logic [7:0] hi, input logic [7:0] lo, input logic pbo);
    return pbo ? 16'h0000 : {hi, lo};
  endfunction
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 0;
    for (int a = 0; a <= 16; a += 4) begin apb(0, 8'(a), 0); chk(rd, 0); end
    apb(0, 8'h14, 0); chk(err, 1); chk(rd, 0);
    repeat (4) begin
      v = 16'($random(seed));
      apb(1, ADDR_SHIFT_LOW, 32'(v[7:0])); apb(1, ADDR_SHIFT_HIGH, 32'(v[15:8]));
      apb(0, ADDR_SHIFT_HIGH, 0); chk(rd, 32'(v[15:8]));
      settle; chk(phase_shift, exp_offset(v[15:8], v[7:0], 1'b0));
    end
    apb(1, ADDR_SHIFT_LOW, 0); apb(1, ADDR_SHIFT_HIGH, 4); settle;
    chk(inverted, 1); chk(phase_shift, HALF_CYCLE_VALUE);
    apb(1, ADDR_CONTROL, 4); settle; chk(phase_shift, exp_offset(8'h04, 8'h00, 1'b1)); chk(inverted, 0);
    apb(0, ADDR_STATUS, 0); chk(rd[STS_IGNORED_BIT], 1);
    apb(1, ADDR_CONTROL, 2); apb(1, ADDR_SHIFT_LOW, 5);
    apb(0, ADDR_STATUS, 0); chk(rd[STS_RAMPING_BIT], 1); chk(phase_shift == 16'h0405, 0);
    repeat (50) @(posedge core_clk); chk(phase_shift, 16'h0405);
    apb(1, ADDR_CONTROL, 1); apb(1, ADDR_SHIFT_HIGH, 8'hF0); settle;
    chk(phase_shift, exp_offset(8'hF0, 8'h05, 1'b0));
    test_done;
  end
  initial begin repeat (5000) @(posedge core_clk); n_mismatch++; test_done; end
endmodule // tb
bind dpo_phase_offset dpo_chk i_dpo_chk (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .inverted, .phase_shift);
`default_nettype wire
